// [core/chg_timer_pkg.sv]
// package for the charge safety timer and temperature zone block
// assumes a 100 MHz clock and a wishbone master with 32-bit data
package chg_timer_pkg;
   localparam int CLK_HZ          = 100_000_000;
   localparam int TICK_SEC        = 1;                    // timer resolution, seconds
   localparam int TICK_CYCLES     = CLK_HZ * TICK_SEC;
   localparam int INT_PULSE_US    = 256;
   localparam int INT_PULSE_CYCLES = INT_PULSE_US * (CLK_HZ / 1_000_000);
   localparam int SEC_PER_HOUR    = 3600;
   localparam int CNT_W           = 17;
   localparam int TICK_W          = 32;
   localparam int PULSE_W         = 16;

   // durations in seconds
   localparam logic [CNT_W-1:0] TRICKLE_SEC   = CNT_W'(1 * SEC_PER_HOUR);
   localparam logic [CNT_W-1:0] PRE_LONG_SEC  = CNT_W'(2 * SEC_PER_HOUR);
   localparam logic [CNT_W-1:0] PRE_SHORT_SEC = CNT_W'(SEC_PER_HOUR / 2);
   localparam logic [CNT_W-1:0] FAST_SEC_0    = CNT_W'(5 * SEC_PER_HOUR);
   localparam logic [CNT_W-1:0] FAST_SEC_1    = CNT_W'(8 * SEC_PER_HOUR);
   localparam logic [CNT_W-1:0] FAST_SEC_2    = CNT_W'(12 * SEC_PER_HOUR);
   localparam logic [CNT_W-1:0] FAST_SEC_3    = CNT_W'(24 * SEC_PER_HOUR);

   // register byte offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_TEMP   = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_FLAG   = 8'h0C;

   // control register fields
   localparam int CTRL_CHG_EN   = 0;
   localparam int CTRL_TMR_EN   = 1;   // three bits: trickle, pre, fast
   localparam int CTRL_HALF_EN  = 4;
   localparam int CTRL_PRE_DUR  = 5;
   localparam int CTRL_FAST_DUR = 6;   // two bits
   localparam logic [7:0] CTRL_RESET = 8'h9F;  // all enabled, pre 2 h, fast 12 h

   // temperature register fields
   localparam int TEMP_ISET  = 0;   // two bits
   localparam int TEMP_VSET  = 2;   // three bits
   localparam int TEMP_IGN   = 5;
   localparam int TEMP_MASK  = 6;
   localparam int TEMP_COOL  = 7;   // two bits
   localparam int TEMP_WARM  = 9;   // two bits
   localparam logic [10:0] TEMP_RESET = 11'h28D;

   // status and flag fields
   localparam int STAT_ZONE    = 0;   // cold, cool, warm, hot
   localparam int STAT_EXPIRED = 4;   // trickle, pre, fast
   localparam int STAT_PHASE   = 7;
   localparam int STAT_HALF    = 9;
   localparam int STAT_TERM    = 10;

   localparam logic [1:0] ISET_SUSPEND = 2'b00;
   localparam logic [1:0] ISET_20      = 2'b01;
   localparam logic [1:0] ISET_40      = 2'b10;
   localparam logic [1:0] ISET_100     = 2'b11;
   localparam logic [2:0] VSET_SUSPEND = 3'b000;

   typedef enum logic [1:0] {
      PH_IDLE    = 2'b00,
      PH_TRICKLE = 2'b01,
      PH_PRE     = 2'b10,
      PH_FAST    = 2'b11
   } phase_e;
endpackage

// [core/charge_safety_timer_temp_zones.sv]
// charge safety timers (trickle, pre, fast) and battery temperature zones
// assumes comparator and regulation inputs synchronous to clk_i, wishbone classic master
`timescale 1ns/10ps
module charge_safety_timer_temp_zones #(
   parameter int TICK_CYCLES      = chg_timer_pkg::TICK_CYCLES,
   parameter int INT_PULSE_CYCLES = chg_timer_pkg::INT_PULSE_CYCLES
) (
   input  wire logic                            clk_i,
   input  wire logic                            rst_i,
   input  wire logic                            wb_cyc_i,
   input  wire logic                            wb_stb_i,
   input  wire logic                            wb_we_i,
   input  wire logic [7:0]                      wb_adr_i,
   input  wire logic [3:0]                      wb_sel_i,
   input  wire logic [31:0]                     wb_dat_i,
   output logic      [31:0]                     wb_dat_o,
   output logic                                 wb_ack_o,
   input  wire logic                            charge_enable_n_i,
   input  wire logic                            vbat_above_shortz_i,
   input  wire logic                            vbat_above_lowv_i,
   input  wire logic                            vbat_above_recharge_i,
   input  wire logic                            cv_loop_i,
   input  wire logic                            below_term_current_i,
   input  wire logic                            recharge_i,
   input  wire logic                            regulation_i,
   input  wire logic                            charge_fault_i,
   input  wire logic                            supplement_i,
   input  wire logic                            beyond_cold_i,
   input  wire logic                            beyond_cool_i,
   input  wire logic                            beyond_warm_i,
   input  wire logic                            beyond_hot_i,
   output logic                                 charge_on_o,
   output chg_timer_pkg::phase_e                phase_o,
   output logic      [1:0]                      current_scale_o,
   output logic                                 voltage_reduce_o,
   output logic      [2:0]                      warm_zone_voltage_select_o,
   output logic      [1:0]                      cool_threshold_select_o,
   output logic      [1:0]                      warm_threshold_select_o,
   output logic                                 terminated_o,
   output logic                                 int_n_o
);
   import chg_timer_pkg::*;

   typedef struct packed {
      logic [TICK_W-1:0]       tick_cnt;
      logic                    half_phase;
      logic                    half_mode;
      logic [2:0][CNT_W-1:0]   tmr;
      logic [2:0]              expired;
      logic [2:0]              tmr_flag;
      logic [3:0]              zone;
      logic [3:0]              zone_flag;
      phase_e                  phase;
      logic                    run_q;
      logic                    terminated;
      logic [7:0]              ctrl;
      logic [7:0]              ctrl_q;
      logic [10:0]             temp;
      logic [PULSE_W-1:0]      int_cnt;
      logic                    ack;
      logic [31:0]             dat;
   } state_s;

   state_s q;
   state_s s;

   function automatic logic [CNT_W-1:0] duration(input int idx, input logic [7:0] c);
      logic [CNT_W-1:0] d;
      d = TRICKLE_SEC;
      if (idx == 1) begin
         d = c[CTRL_PRE_DUR] ? PRE_SHORT_SEC : PRE_LONG_SEC;
      end else if (idx == 2) begin
         case (c[CTRL_FAST_DUR +: 2])
            2'b00:   d = FAST_SEC_0;
            2'b01:   d = FAST_SEC_1;
            2'b10:   d = FAST_SEC_2;
            default: d = FAST_SEC_3;
         endcase
      end
      return d;
   endfunction

   always_comb begin
      logic             run_req;
      logic             ignore;
      logic [3:0]       zone_now;
      logic             temp_ok;
      logic             zone_susp;
      logic             zone_half;
      logic             cycle_on;
      logic             suspend;
      logic             restart;
      logic             tick;
      logic             adv;
      logic             tp_move;
      logic             pf_move;
      logic             event_int;
      logic             hit;
      logic [2:0]       tmr_set;
      logic [3:0]       zflag_set;
      logic [2:0]       clr;
      logic [2:0]       active;
      logic [CNT_W-1:0] dur;
      phase_e           ph;
      s         = q;
      zone_now  = 4'h0;
      temp_ok   = 1'b0;
      zone_susp = 1'b0;
      zone_half = 1'b0;
      cycle_on  = 1'b0;
      suspend   = 1'b0;
      restart   = 1'b0;
      tick      = 1'b0;
      adv       = 1'b0;
      tp_move   = 1'b0;
      pf_move   = 1'b0;
      hit       = 1'b0;
      clr       = 3'b000;
      active    = 3'b000;
      dur       = '0;
      ph        = PH_IDLE;
      tmr_set   = 3'b000;
      zflag_set = 4'h0;
      event_int = 1'b0;
      ignore    = q.temp[TEMP_IGN];
      run_req   = q.ctrl[CTRL_CHG_EN] & ~charge_enable_n_i;

      // zone decode; ignore forces all zone bits low
      zone_now = ignore ? 4'h0 :
                 {beyond_hot_i, beyond_warm_i & ~beyond_hot_i,
                  beyond_cool_i & ~beyond_cold_i, beyond_cold_i};
      temp_ok   = ~zone_now[0] & ~zone_now[3];
      zone_susp = (zone_now[1] & (q.temp[TEMP_ISET +: 2] == ISET_SUSPEND)) |
                  (zone_now[2] & (q.temp[TEMP_VSET +: 3] == VSET_SUSPEND));
      zone_half = zone_now[1] & ((q.temp[TEMP_ISET +: 2] == ISET_20) |
                                 (q.temp[TEMP_ISET +: 2] == ISET_40));

      cycle_on = run_req & ~(|q.expired) & ~q.terminated;
      suspend  = charge_fault_i | supplement_i | ~temp_ok | zone_susp;
      restart  = (run_req & ~q.run_q) | (recharge_i & q.terminated);

      // phase from fixed 2.2 V and low-voltage comparators
      if (!cycle_on) begin
         ph = PH_IDLE;
      end else if (!vbat_above_shortz_i) begin
         ph = PH_TRICKLE;
      end else if (!vbat_above_lowv_i) begin
         ph = PH_PRE;
      end else begin
         ph = PH_FAST;
      end
      s.phase = ph;
      s.run_q = run_req;
      tp_move = ((q.phase == PH_TRICKLE) & (ph == PH_PRE)) |
                ((q.phase == PH_PRE) & (ph == PH_TRICKLE));
      pf_move = ((q.phase == PH_PRE) & (ph == PH_FAST)) |
                ((q.phase == PH_FAST) & (ph == PH_PRE));

      // termination still applies in cool and warm zones
      if (restart) begin
         s.terminated = 1'b0;
      end else if (cycle_on & ~suspend & ~regulation_i & below_term_current_i &
                   vbat_above_recharge_i & cv_loop_i) begin
         s.terminated = 1'b1;
      end

      // a cleared doubling bit only takes hold once regulation ends
      s.half_mode = regulation_i & (q.half_mode | q.ctrl[CTRL_HALF_EN]);

      // common time base; frozen while suspended so no partial tick is lost
      tick = 1'b0;
      if (!suspend) begin
         if (q.tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
            s.tick_cnt = '0;
            tick       = 1'b1;
         end else begin
            s.tick_cnt = q.tick_cnt + 1'b1;
         end
      end
      if (tick) begin
         s.half_phase = ~q.half_phase;
      end
      adv = tick & (~(q.half_mode | zone_half) | q.half_phase);

      clr[0] = tp_move;
      clr[1] = tp_move | pf_move |
               (q.ctrl[CTRL_PRE_DUR] != q.ctrl_q[CTRL_PRE_DUR]);
      clr[2] = pf_move |
               (q.ctrl[CTRL_FAST_DUR +: 2] != q.ctrl_q[CTRL_FAST_DUR +: 2]);
      active[0] = ph == PH_TRICKLE;
      active[1] = ph == PH_PRE;
      active[2] = ph == PH_FAST;
      if (restart) begin
         s.expired = 3'b000;
      end
      for (int i = 0; i < 3; i++) begin
         dur = duration(i, q.ctrl);
         if (restart | clr[i] |
             (q.ctrl[CTRL_TMR_EN + i] & ~q.ctrl_q[CTRL_TMR_EN + i])) begin
            s.tmr[i] = '0;
         end else if (q.ctrl[CTRL_TMR_EN + i] & active[i] & adv) begin
            if (q.tmr[i] >= dur - 1'b1) begin
               s.expired[i] = 1'b1;
               tmr_set[i]   = 1'b1;
               event_int    = 1'b1;
            end else begin
               s.tmr[i] = q.tmr[i] + 1'b1;
            end
         end
      end

      // zone change: status, flag, interrupt unless masked
      if (zone_now != q.zone) begin
         s.zone = zone_now;
         if (!ignore) begin
            zflag_set = zone_now;
            event_int = event_int | ~q.temp[TEMP_MASK];
         end
      end

      // wishbone: one wait state, registered ack and data
      hit       = wb_cyc_i & wb_stb_i & ~q.ack;
      s.ack     = hit;
      s.dat     = 32'h0000_0000;
      s.ctrl_q  = q.ctrl;
      if (hit & wb_we_i) begin
         case (wb_adr_i)
            REG_CTRL: begin
               if (wb_sel_i[0]) begin
                  s.ctrl = wb_dat_i[7:0];
               end
            end
            REG_TEMP: begin
               if (wb_sel_i[0]) begin
                  s.temp[7:0] = wb_dat_i[7:0];
               end
               if (wb_sel_i[1]) begin
                  s.temp[10:8] = wb_dat_i[10:8];
               end
            end
            REG_FLAG: begin
               if (wb_sel_i[0]) begin
                  s.zone_flag = q.zone_flag & ~wb_dat_i[3:0];
                  s.tmr_flag  = q.tmr_flag & ~wb_dat_i[6:4];
               end
            end
            default: begin
            end
         endcase
      end else if (hit) begin
         case (wb_adr_i)
            REG_CTRL:   s.dat = {24'h00_0000, q.ctrl};
            REG_TEMP:   s.dat = {21'h00_0000, q.temp};
            REG_STATUS: s.dat = {21'h00_0000, q.terminated, q.half_mode, q.phase,
                                 q.expired, q.zone};
            REG_FLAG:   s.dat = {25'h000_0000, q.tmr_flag, q.zone_flag};
            default:    s.dat = 32'h0000_0000;
         endcase
      end
      // hardware set wins over a same-cycle software clear
      s.zone_flag = s.zone_flag | zflag_set;
      s.tmr_flag  = s.tmr_flag | tmr_set;

      // back-to-back events inside one pulse merge into it
      if (q.int_cnt != '0) begin
         s.int_cnt = q.int_cnt - 1'b1;
      end else if (event_int) begin
         s.int_cnt = PULSE_W'(INT_PULSE_CYCLES);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q            <= '0;
         q.ctrl       <= CTRL_RESET;
         q.ctrl_q     <= CTRL_RESET;
         q.temp       <= TEMP_RESET;
         q.phase      <= PH_IDLE;
      end else begin
         q <= s;
      end
   end

   always_comb begin
      charge_on_o = (q.phase != PH_IDLE) & ~charge_fault_i & ~supplement_i &
                    ~(q.zone[0] | q.zone[3]) &
                    ~(q.zone[1] & (q.temp[TEMP_ISET +: 2] == ISET_SUSPEND)) &
                    ~(q.zone[2] & (q.temp[TEMP_VSET +: 3] == VSET_SUSPEND));
      current_scale_o = q.zone[1] ? q.temp[TEMP_ISET +: 2] : ISET_100;
      voltage_reduce_o = q.zone[2];
   end

   assign wb_ack_o                   = q.ack;
   assign wb_dat_o                   = q.dat;
   assign phase_o                    = q.phase;
   assign warm_zone_voltage_select_o = q.temp[TEMP_VSET +: 3];
   assign cool_threshold_select_o    = q.temp[TEMP_COOL +: 2];
   assign warm_threshold_select_o    = q.temp[TEMP_WARM +: 2];
   assign terminated_o               = q.terminated;
   assign int_n_o                    = (q.int_cnt == '0);

endmodule // charge_safety_timer_temp_zones

// [verif/chg_timer_monitor.sv]
// bound checker for the charge safety timer block
// assumes bind onto the top module; sees only its ports
`timescale 1ns/10ps
module chg_timer_monitor
   import chg_timer_pkg::*;
#(
   parameter int INT_PULSE_CYCLES = 25600
) (
   input wire logic                  clk_i,
   input wire logic                  rst_i,
   input wire logic                  wb_cyc_i,
   input wire logic                  wb_stb_i,
   input wire logic                  wb_we_i,
   input wire logic [7:0]            wb_adr_i,
   input wire logic [3:0]            wb_sel_i,
   input wire logic [31:0]           wb_dat_i,
   input wire logic [31:0]           wb_dat_o,
   input wire logic                  wb_ack_o,
   input wire logic                  vbat_above_shortz_i,
   input wire logic                  vbat_above_lowv_i,
   input wire logic                  beyond_cold_i,
   input wire logic                  beyond_cool_i,
   input wire logic                  beyond_hot_i,
   input wire logic                  charge_on_o,
   input wire chg_timer_pkg::phase_e phase_o,
   input wire logic [1:0]            current_scale_o,
   input wire logic                  int_n_o
);
   // shadow of ignore and mask, one cycle behind the block
   typedef struct packed {
      logic        ign;
      logic        mask;
      logic [15:0] low_cnt;
   } mon_s;
   mon_s st;
   mon_s next_st;
   always_comb begin
      next_st = st;
      if (wb_ack_o && wb_we_i && wb_adr_i == REG_TEMP && wb_sel_i[0]) begin
         next_st.ign  = wb_dat_i[TEMP_IGN];
         next_st.mask = wb_dat_i[TEMP_MASK];
      end
      next_st.low_cnt = int_n_o ? 16'h0000 : st.low_cnt + 16'h0001;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) st <= '0;
      else st <= next_st;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_ACK_ANSWER: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("no ack");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
   AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
   AST_INT_WIDTH:
      assert property ($rose(int_n_o) |-> st.low_cnt == INT_PULSE_CYCLES) else $error("pulse width wrong");
   AST_INT_BOUND:
      assert property (st.low_cnt <= INT_PULSE_CYCLES) else $error("pulse too long");
   AST_IGNORE_ZERO:
      assert property ((wb_ack_o && !wb_we_i && wb_adr_i == REG_STATUS && st.ign) |-> wb_dat_o[3:0] == 4'h0)
         else $error("zone bits set while ignored");
   AST_ZONE_INT:
      assert property (($rose(beyond_cool_i) && !beyond_cold_i && !st.ign && !st.mask && int_n_o) |=> !int_n_o)
         else $error("zone change without pulse");
   AST_HOT_STOP:
      assert property ((beyond_hot_i && $past(beyond_hot_i) && !st.ign && !$past(st.ign)) |-> !charge_on_o)
         else $error("charging while hot");
   AST_PRE_PHASE:
      assert property (phase_o == PH_PRE |-> $past(vbat_above_shortz_i) && !$past(vbat_above_lowv_i))
         else $error("pre phase off its window");
   AST_SCALE_NORMAL:
      assert property ((!beyond_cool_i && !$past(beyond_cool_i)) |-> current_scale_o == 2'b11)
         else $error("current reduced outside cool");
endmodule // chg_timer_monitor

bind charge_safety_timer_temp_zones chg_timer_monitor #(.INT_PULSE_CYCLES(INT_PULSE_CYCLES)) mon (.clk_i, .rst_i,
   .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .vbat_above_shortz_i,
   .vbat_above_lowv_i, .beyond_cold_i, .beyond_cool_i, .beyond_hot_i, .charge_on_o, .phase_o, .current_scale_o,
   .int_n_o);

// [verif/chg_host_model.sv]
// host model: classic wishbone master and interrupt pulse counter
// assumes a slave that acks each request once
`timescale 1ns/10ps
module chg_host_model (
   input  wire logic        clk_i,
   input  wire logic        ack_i,
   input  wire logic [31:0] dat_i,
   input  wire logic        int_n_i,
   output logic             cyc_o,
   output logic             stb_o,
   output logic             we_o,
   output logic [7:0]       adr_o,
   output logic [3:0]       sel_o,
   output logic [31:0]      dat_o
);
   int int_cnt = 0;
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o  = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'h0;
      dat_o = 32'h0;
   end
   always @(negedge int_n_i) int_cnt++;
   // one classic cycle; waits for ack, no latency assumed
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wdat, output logic [31:0] rdat);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o  <= we;
      adr_o <= adr;
      sel_o <= 4'h3;
      dat_o <= wdat;
      do @(posedge clk_i); while (ack_i !== 1'b1);
      rdat = dat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      dat_o <= ~wdat; // stale data must not look valid
   endtask
endmodule // chg_host_model

// [verif/charge_safety_timer_temp_zones_bench.sv]
// self-checking bench for the charge safety timer block
// assumes the host model and the bound checker are compiled first
`timescale 1ns/10ps
module charge_safety_timer_temp_zones_bench;
   import chg_timer_pkg::*;
   localparam int TICK = 4;
   logic clk_i = 0, rst_i = 1, charge_enable_n_i = 0, vbat_above_shortz_i = 1, vbat_above_lowv_i = 0;
   logic regulation_i = 0, charge_fault_i = 0, supplement_i = 0;
   logic vbat_above_recharge_i = 0, cv_loop_i = 0, below_term_current_i = 0, recharge_i = 0;
   logic beyond_cold_i = 0, beyond_cool_i = 0, beyond_warm_i = 0, beyond_hot_i = 0;
   logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, charge_on_o, int_n_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   int error_cnt = 0;
   int n_tests = 0;
   initial forever #5 clk_i = ~clk_i;
   chg_host_model host (.clk_i, .ack_i(wb_ack_o), .dat_i(wb_dat_o), .int_n_i(int_n_o), .cyc_o(wb_cyc_i),
      .stb_o(wb_stb_i), .we_o(wb_we_i), .adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i));
   charge_safety_timer_temp_zones #(.TICK_CYCLES(TICK), .INT_PULSE_CYCLES(8)) dut (.clk_i, .rst_i, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .charge_enable_n_i,
      .vbat_above_shortz_i, .vbat_above_lowv_i, .vbat_above_recharge_i, .cv_loop_i,
      .below_term_current_i, .recharge_i, .regulation_i, .charge_fault_i, .supplement_i,
      .beyond_cold_i, .beyond_cool_i, .beyond_warm_i, .beyond_hot_i, .charge_on_o, .phase_o(), .current_scale_o(),
      .voltage_reduce_o(), .warm_zone_voltage_select_o(), .cool_threshold_select_o(), .warm_threshold_select_o(),
      .terminated_o(), .int_n_o);
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] unused;
      host.xfer(1'b1, a, d, unused);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      host.xfer(1'b0, a, 32'h0, d);
   endtask
   task automatic restart(input logic [7:0] c);
      wr(REG_CTRL, {24'h0, c & 8'hFE});
      wr(REG_CTRL, {24'h0, c});
   endtask
   // expired bit must be clear just before and settled just after
   task automatic timed(input int cyc, input int b, input logic last, input string what);
      logic [31:0] s;
      repeat (cyc - 40) @(posedge clk_i);
      rd(REG_STATUS, s);
      check(32'(s[b]), 32'h0, what);
      repeat (80) @(posedge clk_i);
      rd(REG_STATUS, s);
      check(32'(s[b]), 32'(last), what);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge clk_i);
      error_cnt++;
      $display("wrong value at %0t: watchdog ran out", $time);
      results();
   end
   initial begin
      logic [31:0] d;
      int n;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(REG_CTRL, d);
      check(32'(d[7:5]), 32'h4, "ctrl durations at reset");
      rd(8'h10, d);
      check(d, 32'h0, "unmapped read");
      $display("test reset done");
      n = host.int_cnt;
      restart(8'hBF);
      timed(1800 * TICK, STAT_EXPIRED + 1, 1'b1, "pre half hour");
      check(32'(host.int_cnt - n), 32'h1, "expiry pulse count");
      regulation_i <= 1'b1;
      restart(8'hBF);
      timed(3600 * TICK, STAT_EXPIRED + 1, 1'b1, "pre at half rate");
      regulation_i <= 1'b0;
      wr(REG_CTRL, 32'hAE);
      regulation_i <= 1'b1;
      restart(8'hAF);
      timed(1800 * TICK, STAT_EXPIRED + 1, 1'b1, "half rate disabled");
      regulation_i <= 1'b0;
      $display("test pre timer done");
      vbat_above_shortz_i <= 1'b0;
      restart(8'hBF);
      repeat (4000) @(posedge clk_i);
      charge_fault_i <= 1'b1;
      repeat (1000) @(posedge clk_i);
      charge_fault_i <= 1'b0;
      supplement_i <= 1'b1;
      repeat (1000) @(posedge clk_i);
      supplement_i <= 1'b0;
      timed(3600 * TICK - 4000, STAT_EXPIRED, 1'b1, "trickle with freeze");
      vbat_above_shortz_i <= 1'b1;
      restart(8'hBB);
      timed(1800 * TICK, STAT_EXPIRED + 1, 1'b0, "pre disabled");
      $display("test trickle and enable done");
      n = host.int_cnt;
      beyond_cool_i <= 1'b1;
      rd(REG_STATUS, d);
      check(32'(d[3:0]), 32'h2, "cool zone bits");
      check(32'(host.int_cnt - n), 32'h1, "cool pulse");
      wr(REG_TEMP, 32'h2CD);
      beyond_cool_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      rd(REG_STATUS, d);
      check(32'(d[3:0]), 32'h0, "normal zone bits");
      check(32'(host.int_cnt - n), 32'h1, "masked pulse");
      wr(REG_TEMP, 32'h2AD);
      beyond_warm_i <= 1'b1;
      beyond_hot_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      rd(REG_STATUS, d);
      check(32'(d[3:0]), 32'h0, "ignored zone bits");
      check(32'(charge_on_o), 32'h1, "ignored hot charges");
      wr(REG_TEMP, 32'h28D);
      repeat (20) @(posedge clk_i);
      rd(REG_STATUS, d);
      check(32'(d[3:0]), 32'h8, "hot zone bits");
      check(32'(host.int_cnt - n), 32'h2, "hot pulse");
      check(32'(charge_on_o), 32'h0, "hot stops charge");
      beyond_hot_i <= 1'b0;
      beyond_warm_i <= 1'b0;
      $display("test zones done");
      beyond_cool_i <= 1'b1;
      vbat_above_recharge_i <= 1'b1;
      cv_loop_i <= 1'b1;
      below_term_current_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      rd(REG_STATUS, d);
      check(32'(d[STAT_TERM]), 32'h1, "terminated in cool zone");
      vbat_above_recharge_i <= 1'b0;
      cv_loop_i <= 1'b0;
      below_term_current_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      recharge_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      recharge_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      rd(REG_STATUS, d);
      check(32'(d[STAT_TERM]), 32'h0, "recharge restarts cycle");
      beyond_cool_i <= 1'b0;
      $display("test termination done");
      results();
   end
endmodule // charge_safety_timer_temp_zones_bench
